// ===== slt_pkg.sv
/*
  Constants, register map and carrier types for the switch lookup table
  indirect access block.
  Assumes a 32-bit AHB-Lite register bus and a 125 MHz core clock.
*/
// Functional notes
// - Static word2 bit 31 is port_state_bypass; set means port_state_bypass port state.
// - Static word2 bit 30 enables filter group matching for multicast packets.
// - Static word2 bits 6:0 egress_port_mask, bit 0 is port 1.
// - Word3 holds filter_group_id 22:16 and MAC 47:32; word4 holds MAC 31:0.
// - Reserved multicast table holds 8 group masks for 48 addresses indexed by address low 6 bits.
// - Writing one multicast address mask updates all addresses in its group.
// - Multicast mask uses the word2 location 0x0424; bits 31:30 reserved.
// - Multicast read with table 1, read, go returns mask in data register.
// - Device clears go_done_bit itself when the table access completes.
// - With VLAN mode enabled, ingress packets fetch VLAN info from the table.
// - VLAN table has 4096 entries selected directly by the packet VID.
// - VLAN entry has valid flag and membership_route_choice bit.
// - VLAN entry holds 3-bit priority and 3-bit spanning_instance_number.
// - VLAN entry holds 7-bit filter_group_id used for address table hashing.
// - VLAN entry holds 7-bit egress_strip_mask, set bit untags at that port.
// - VLAN entry holds 7-bit membership mask, bit 0 is port 1.
// - VLAN access control start flag at bit 7 clears when done.
// - VLAN read: index, start read, then entry appears in data registers.
package slt_pkg;
  localparam logic [11:0] SLT_OFS_STAT_W1 = 12'h420;
  localparam logic [11:0] SLT_OFS_STAT_W2 = 12'h424;
  localparam logic [11:0] SLT_OFS_STAT_W3 = 12'h428;
  localparam logic [11:0] SLT_OFS_STAT_W4 = 12'h42c;
  localparam logic [11:0] SLT_OFS_STAT_CTL = 12'h41c;
  localparam logic [11:0] SLT_OFS_VLAN_E0 = 12'h400;
  localparam logic [11:0] SLT_OFS_VLAN_E1 = 12'h404;
  localparam logic [11:0] SLT_OFS_VLAN_E2 = 12'h408;
  localparam logic [11:0] SLT_OFS_VLAN_IDX = 12'h40c;
  localparam logic [11:0] SLT_OFS_VLAN_CTL = 12'h410;
  localparam logic [11:0] SLT_OFS_LKUP_CTL = 12'h414;
  // Static / multicast and VLAN control fields
  localparam int SLT_CTL_GO_BIT = 7;
  localparam int SLT_CTL_TBL_BIT = 6;
  localparam int SLT_CTL_DIR_BIT = 5;
  localparam int SLT_CTL_SEL_LSB = 8;
  localparam int SLT_VCTL_START_BIT = 7;
  localparam int SLT_VCTL_DIR_BIT = 0;
  // Static word2 fields, data word masks, table sizes and bus constants
  localparam int SLT_W2_BYPASS_BIT = 31;
  localparam int SLT_W2_FGM_BIT = 30;
  localparam logic [31:0] SLT_W2_MASK = 32'hc000007f;
  localparam logic [31:0] SLT_MC_MASK = 32'hc000007f;
  localparam logic [31:0] SLT_W3_MASK = 32'h007fffff;
  localparam logic [31:0] SLT_W1_MASK = 32'hfc000007;
  localparam logic [31:0] SLT_RST_WORD = 32'h00000000;
  localparam int SLT_NPORT = 7;
  localparam int SLT_MC_ENTRIES = 48;
  localparam int SLT_MC_GROUPS = 8;
  localparam int SLT_STAT_ENTRIES = 16;
  localparam int SLT_VLAN_ENTRIES = 4096;
  localparam int SLT_OP_CYCLES = 2;
  localparam logic [1:0] SLT_HTRANS_NONSEQ = 2'b10;

  // VLAN entry layout
  typedef struct packed {
    logic valid;
    logic membership_route_choice;
    logic [2:0] priority_val;
    logic [2:0] spanning_instance_number;
    logic [6:0] filter_group_id;
    logic [6:0] egress_strip_mask;
    logic [6:0] membership_mask;
  } slt_vlan_s;

  // Result of an ingress VLAN lookup
  typedef struct packed {
    logic hit;
    slt_vlan_s entry;
  } slt_vres_s;

  typedef enum logic [1:0] {
    SLT_IDLE = 2'b00,
    SLT_BUSY = 2'b01,
    SLT_DONE = 2'b11
  } slt_st_e;
endpackage : slt_pkg

// ===== slt_top.sv
/*
  Indirect access to the static address, reserved multicast and VLAN tables.
  Assumes one AHB-Lite master, word transfers, and an ingress VID strobe from
  the lookup engine on the same clock.
*/
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/1ps
module slt_top #(
  parameter int VID_W = 12
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // Ingress VLAN lookup
  input wire logic lkup_req_in,
  input wire logic [VID_W-1:0] lkup_vid_in,
  output slt_pkg::slt_vres_s lkup_res_out,
  output logic lkup_vld_out,
  // Static entry port for the forwarding datapath
  input wire logic [3:0] stat_sel_in,
  output logic [31:0] stat_w2_out,
  output logic [31:0] stat_w3_out,
  output logic [31:0] stat_w4_out,
  // Reserved multicast lookup
  input wire logic [5:0] mc_addr_in,
  output logic [slt_pkg::SLT_NPORT-1:0] mc_mask_out
);
  import slt_pkg::*;

  // Reset synchroniser
  logic rst_s1_r, rst_s2_r;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  wire rstn = rst_s2_r;

  // Tables
  logic [31:0] stat_w1_mem [SLT_STAT_ENTRIES];
  logic [31:0] stat_w2_mem [SLT_STAT_ENTRIES];
  logic [31:0] stat_w3_mem [SLT_STAT_ENTRIES];
  logic [31:0] stat_w4_mem [SLT_STAT_ENTRIES];
  logic [SLT_NPORT+1:0] mc_grp_r [SLT_MC_GROUPS];
  slt_vlan_s vlan_mem [SLT_VLAN_ENTRIES];

  // Host-visible registers
  logic [31:0] w1_r, w2_r, w3_r, w4_r, ve0_r, ve1_r, ve2_r;
  logic [VID_W-1:0] vidx_r;
  logic [13:0] sctl_r;
  logic vdir_r, vlan_mode_r;
  slt_st_e sst_r, vst_r;

  // AHB address phase capture
  logic dp_wr_r, dp_rd_r;
  logic [11:0] dp_addr_r;
  wire ap_take = hsel_in & hready_in & htrans_in[1];
  always_ff @(posedge clk_in or negedge rstn) begin
    if (!rstn) begin
      dp_wr_r <= 1'b0;
      dp_rd_r <= 1'b0;
      dp_addr_r <= 12'h000;
    end else begin
      dp_wr_r <= ap_take & hwrite_in;
      dp_rd_r <= ap_take & ~hwrite_in;
      dp_addr_r <= ap_take ? haddr_in[11:0] : dp_addr_r;
    end
  end

  // Write decode
  wire s_busy = (sst_r != SLT_IDLE);
  wire v_busy = (vst_r != SLT_IDLE);
  wire wr_w1 = dp_wr_r & (dp_addr_r == SLT_OFS_STAT_W1) & ~s_busy;
  wire wr_w2 = dp_wr_r & (dp_addr_r == SLT_OFS_STAT_W2) & ~s_busy;
  wire wr_w3 = dp_wr_r & (dp_addr_r == SLT_OFS_STAT_W3) & ~s_busy;
  wire wr_w4 = dp_wr_r & (dp_addr_r == SLT_OFS_STAT_W4) & ~s_busy;
  wire wr_sctl = dp_wr_r & (dp_addr_r == SLT_OFS_STAT_CTL) & ~s_busy;
  wire wr_ve0 = dp_wr_r & (dp_addr_r == SLT_OFS_VLAN_E0) & ~v_busy;
  wire wr_ve1 = dp_wr_r & (dp_addr_r == SLT_OFS_VLAN_E1) & ~v_busy;
  wire wr_ve2 = dp_wr_r & (dp_addr_r == SLT_OFS_VLAN_E2) & ~v_busy;
  wire wr_vidx = dp_wr_r & (dp_addr_r == SLT_OFS_VLAN_IDX) & ~v_busy;
  wire wr_vctl = dp_wr_r & (dp_addr_r == SLT_OFS_VLAN_CTL) & ~v_busy;
  wire wr_lkup = dp_wr_r & (dp_addr_r == SLT_OFS_LKUP_CTL);
  wire s_go = wr_sctl & hwdata_in[SLT_CTL_GO_BIT];
  wire v_go = wr_vctl & hwdata_in[SLT_VCTL_START_BIT];

  // Control field decode
  wire s_tbl = sctl_r[SLT_CTL_TBL_BIT];
  wire s_rd = sctl_r[SLT_CTL_DIR_BIT];
  wire [5:0] s_sel = sctl_r[SLT_CTL_SEL_LSB +: 6];
  wire [3:0] st_idx = s_sel[3:0];
  // Group of a reserved address: six consecutive addresses share one group
  function automatic logic [2:0] mc_group(input logic [5:0] a);
    mc_group = (a < 6'(SLT_MC_ENTRIES)) ? 3'(a / 6'(SLT_MC_ENTRIES / SLT_MC_GROUPS)) : 3'h7;
  endfunction
  wire [2:0] s_grp = mc_group(s_sel);
  wire s_exec = (sst_r == SLT_BUSY);
  wire v_exec = (vst_r == SLT_BUSY);

  // Static and multicast control state
  logic [1:0] s_cnt_r, v_cnt_r;
  always_ff @(posedge clk_in or negedge rstn) begin
    if (!rstn) begin
      sst_r <= SLT_IDLE;
      sctl_r <= 14'h0000;
      s_cnt_r <= 2'h0;
    end else begin
      case (sst_r)
        SLT_IDLE: begin
          if (wr_sctl) begin
            sctl_r <= hwdata_in[13:0];
          end
          if (s_go) begin
            sst_r <= SLT_BUSY;
            s_cnt_r <= 2'(SLT_OP_CYCLES - 1);
          end
        end
        SLT_BUSY: begin
          s_cnt_r <= s_cnt_r - 2'h1;
          if (s_cnt_r == 2'h1) begin
            sst_r <= SLT_DONE;
          end
        end
        SLT_DONE: begin
          sst_r <= SLT_IDLE;
          sctl_r[SLT_CTL_GO_BIT] <= 1'b0;
        end
        default: sst_r <= SLT_IDLE;
      endcase
    end
  end
  wire s_act = s_exec & (s_cnt_r == 2'h1);

  // Static data words; read result loads at the action cycle
  always_ff @(posedge clk_in or negedge rstn) begin
    if (!rstn) begin
      w1_r <= SLT_RST_WORD;
      w2_r <= SLT_RST_WORD;
      w3_r <= SLT_RST_WORD;
      w4_r <= SLT_RST_WORD;
    end else if (s_act & s_rd) begin
      w1_r <= s_tbl ? w1_r : stat_w1_mem[st_idx];
      w2_r <= s_tbl ? {2'b00, 23'h0, mc_grp_r[s_grp][SLT_NPORT-1:0]}
                    : stat_w2_mem[st_idx];
      w3_r <= s_tbl ? w3_r : stat_w3_mem[st_idx];
      w4_r <= s_tbl ? w4_r : stat_w4_mem[st_idx];
    end else begin
      w1_r <= wr_w1 ? (hwdata_in & SLT_W1_MASK) : w1_r;
      w2_r <= wr_w2 ? (hwdata_in & SLT_W2_MASK) : w2_r;
      w3_r <= wr_w3 ? (hwdata_in & SLT_W3_MASK) : w3_r;
      w4_r <= wr_w4 ? hwdata_in : w4_r;
    end
  end

  // Static table and multicast group storage
  always_ff @(posedge clk_in) begin
    if (s_act & ~s_rd & ~s_tbl) begin
      stat_w1_mem[st_idx] <= w1_r;
      stat_w2_mem[st_idx] <= w2_r;
      stat_w3_mem[st_idx] <= w3_r;
      stat_w4_mem[st_idx] <= w4_r;
    end
  end
  // One mask per group, so a write lands on every address of the group
  always_ff @(posedge clk_in or negedge rstn) begin
    if (!rstn) begin
      for (int g = 0; g < SLT_MC_GROUPS; g++) begin
        mc_grp_r[g] <= '0;
      end
    end else if (s_act & ~s_rd & s_tbl) begin
      mc_grp_r[s_grp] <= {2'b00, w2_r[SLT_NPORT-1:0]};
    end
  end

  // Datapath views of the tables, registered
  wire [2:0] mc_out_grp = mc_group(mc_addr_in);
  always_ff @(posedge clk_in) begin
    stat_w2_out <= stat_w2_mem[stat_sel_in];
    stat_w3_out <= stat_w3_mem[stat_sel_in];
    stat_w4_out <= stat_w4_mem[stat_sel_in];
  end
  always_ff @(posedge clk_in or negedge rstn) begin
    if (!rstn) begin
      mc_mask_out <= '0;
    end else begin
      mc_mask_out <= mc_grp_r[mc_out_grp][SLT_NPORT-1:0];
    end
  end

  // VLAN control state
  always_ff @(posedge clk_in or negedge rstn) begin
    if (!rstn) begin
      vst_r <= SLT_IDLE;
      vdir_r <= 1'b0;
      v_cnt_r <= 2'h0;
      vidx_r <= '0;
      vlan_mode_r <= 1'b0;
    end else begin
      vidx_r <= wr_vidx ? hwdata_in[VID_W-1:0] : vidx_r;
      vlan_mode_r <= wr_lkup ? hwdata_in[0] : vlan_mode_r;
      case (vst_r)
        SLT_IDLE: begin
          if (v_go) begin
            vst_r <= SLT_BUSY;
            vdir_r <= hwdata_in[SLT_VCTL_DIR_BIT];
            v_cnt_r <= 2'(SLT_OP_CYCLES - 1);
          end
        end
        SLT_BUSY: begin
          v_cnt_r <= v_cnt_r - 2'h1;
          if (v_cnt_r == 2'h1) begin
            vst_r <= SLT_DONE;
          end
        end
        SLT_DONE: vst_r <= SLT_IDLE;
        default: vst_r <= SLT_IDLE;
      endcase
    end
  end
  wire v_act = v_exec & (v_cnt_r == 2'h1);

  // VLAN entry packing, {e2,e1,e0} low bits hold the entry
  slt_vlan_s v_wr_ent;
  assign v_wr_ent = slt_vlan_s'({ve2_r[0], ve1_r[0], ve1_r[15:13],
                                 ve1_r[12:10], ve1_r[9:3], ve0_r[13:7],
                                 ve0_r[6:0]});
  slt_vlan_s v_rd_ent;
  assign v_rd_ent = vlan_mem[vidx_r];

  // VLAN data words and table
  always_ff @(posedge clk_in or negedge rstn) begin
    if (!rstn) begin
      ve0_r <= SLT_RST_WORD;
      ve1_r <= SLT_RST_WORD;
      ve2_r <= SLT_RST_WORD;
    end else if (v_act & vdir_r) begin
      ve0_r <= {18'h0, v_rd_ent.egress_strip_mask, v_rd_ent.membership_mask};
      ve1_r <= {16'h0, v_rd_ent.priority_val, v_rd_ent.spanning_instance_number,
                v_rd_ent.filter_group_id, 2'b00, v_rd_ent.membership_route_choice};
      ve2_r <= {31'h0, v_rd_ent.valid};
    end else begin
      ve0_r <= wr_ve0 ? {18'h0, hwdata_in[13:0]} : ve0_r;
      ve1_r <= wr_ve1 ? {16'h0, hwdata_in[15:3], 2'b00, hwdata_in[0]} : ve1_r;
      ve2_r <= wr_ve2 ? {31'h0, hwdata_in[0]} : ve2_r;
    end
  end
  always_ff @(posedge clk_in) begin
    if (v_act & ~vdir_r) begin
      vlan_mem[vidx_r] <= v_wr_ent;
    end
  end

  // Ingress VLAN lookup, direct by VID
  always_ff @(posedge clk_in or negedge rstn) begin
    if (!rstn) begin
      lkup_res_out <= '0;
      lkup_vld_out <= 1'b0;
    end else begin
      lkup_vld_out <= lkup_req_in & vlan_mode_r;
      lkup_res_out.entry <= vlan_mem[lkup_vid_in];
      lkup_res_out.hit <= vlan_mem[lkup_vid_in].valid;
    end
  end

  // Read mux
  wire [31:0] sctl_rd = {18'h0, sctl_r[13:8], sctl_r[7] | s_busy, sctl_r[6:0]};
  wire [31:0] vctl_rd = {24'h0, v_busy, 6'h0, vdir_r};
  logic [31:0] rd_mux;
  always_comb begin
    case (dp_addr_r)
      SLT_OFS_STAT_W1: rd_mux = w1_r;
      SLT_OFS_STAT_W2: rd_mux = w2_r;
      SLT_OFS_STAT_W3: rd_mux = w3_r;
      SLT_OFS_STAT_W4: rd_mux = w4_r;
      SLT_OFS_STAT_CTL: rd_mux = sctl_rd;
      SLT_OFS_VLAN_E0: rd_mux = ve0_r;
      SLT_OFS_VLAN_E1: rd_mux = ve1_r;
      SLT_OFS_VLAN_E2: rd_mux = ve2_r;
      SLT_OFS_VLAN_IDX: rd_mux = {20'h0, vidx_r};
      SLT_OFS_VLAN_CTL: rd_mux = vctl_rd;
      SLT_OFS_LKUP_CTL: rd_mux = {31'h0, vlan_mode_r};
      default: rd_mux = 32'h00000000;
    endcase
  end
  assign hrdata_out = dp_rd_r ? rd_mux : 32'h00000000;
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;

  // Checks
  a_go_self_clear: assert property (@(posedge clk_in) disable iff (!rstn)
    s_go |-> ##[1:4] !sctl_rd[SLT_CTL_GO_BIT]) else $error("go bit not cleared");
  a_vlan_start_clr: assert property (@(posedge clk_in) disable iff (!rstn)
    v_go |=> v_busy ##[1:3] !v_busy) else $error("vlan start not cleared");
  a_busy_ignore: assert property (@(posedge clk_in) disable iff (!rstn)
    (s_busy & ~(s_act & s_rd) & dp_wr_r & (dp_addr_r == SLT_OFS_STAT_W4)) |=> $stable(w4_r))
    else $error("write accepted while busy");
  a_w2_stable: assert property (@(posedge clk_in) disable iff (!rstn)
    (s_exec & ~s_rd) |=> $stable(w2_r)) else $error("word2 changed busy");
  a_w2_reserved: assert property (@(posedge clk_in) disable iff (!rstn)
    w2_r[29:7] == 23'h0) else $error("word2 reserved set");
  a_w3_reserved: assert property (@(posedge clk_in) disable iff (!rstn)
    w3_r[31:23] == 9'h0) else $error("word3 reserved set");
  a_lkup_mode: assert property (@(posedge clk_in) disable iff (!rstn)
    lkup_vld_out |-> $past(vlan_mode_r)) else $error("lookup without mode");
  a_mc_group: assert property (@(posedge clk_in) disable iff (!rstn)
    (s_act & ~s_rd & s_tbl) |=> mc_grp_r[$past(s_grp)][6:0] == $past(w2_r[6:0]))
    else $error("mc group not written");
  a_vlan_rd: assert property (@(posedge clk_in) disable iff (!rstn)
    (v_act & vdir_r) |=> ve2_r[0] == $past(v_rd_ent.valid))
    else $error("vlan read wrong");
endmodule : slt_top

// ===== switch_lookup_table_indirect_access_test.sv
/*
  Self-checking bench for the lookup table indirect access block.
  Assumes slt_pkg and slt_top are compiled first; drives the AHB-Lite port itself.
*/
`timescale 1ns/1ps
module switch_lookup_table_indirect_access_test;
  import slt_pkg::*;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic hsel_in = 1'b0;
  logic hwrite_in = 1'b0;
  logic lkup_req_in = 1'b0;
  logic [31:0] haddr_in = 32'h0;
  logic [31:0] hwdata_in = 32'h0;
  logic [1:0] htrans_in = 2'h0;
  logic [2:0] hsize_in = 3'h2;
  logic [11:0] lkup_vid_in = 12'h0;
  logic [3:0] stat_sel_in = 4'h0;
  logic [5:0] mc_addr_in = 6'h0;
  logic [31:0] hrdata_out, stat_w2_out, stat_w3_out, stat_w4_out, rd_q;
  logic hreadyout_out, hresp_out, lkup_vld_out, rdy_q, rsp_q;
  logic [SLT_NPORT-1:0] mc_mask_out;
  slt_vres_s lkup_res_out;
  int err_total = 0;
  int checked = 0;

  slt_top #(.VID_W(12)) dut_u (
    .clk_in(clk_in), .rstn_in(rstn_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in),
    .hwdata_in(hwdata_in), .hready_in(hreadyout_out), .hrdata_out(hrdata_out),
    .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .lkup_req_in(lkup_req_in),
    .lkup_vid_in(lkup_vid_in), .lkup_res_out(lkup_res_out), .lkup_vld_out(lkup_vld_out),
    .stat_sel_in(stat_sel_in), .stat_w2_out(stat_w2_out), .stat_w3_out(stat_w3_out),
    .stat_w4_out(stat_w4_out), .mc_addr_in(mc_addr_in), .mc_mask_out(mc_mask_out)
  );

  // 125 MHz clock
  always #4 clk_in = ~clk_in;

  // Bus answer as seen at each rising edge
  always @(posedge clk_in) begin
    rdy_q <= hreadyout_out;
    rsp_q <= hresp_out;
    rd_q <= hrdata_out;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk

  // Step past an edge so its updates have landed
  task automatic tick();
    @(posedge clk_in);
    #1;
  endtask : tick

  // Wait for hready under a bound
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      tick();
      n++;
    end while (rdy_q !== 1'b1 && n < 50);
    if (rdy_q !== 1'b1) begin
      err_total++;
      tally_and_finish();
    end
  endtask : wait_rdy

  // One single-word transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [11:0] ofs, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel_in <= 1'b1;
    haddr_in <= {20'h0, ofs};
    htrans_in <= SLT_HTRANS_NONSEQ;
    hwrite_in <= wr;
    wait_rdy();
    htrans_in <= 2'h0;
    hsel_in <= 1'b0;
    hwdata_in <= wd;
    wait_rdy();
    rd = rd_q;
    chk("bus response", {31'h0, rsp_q}, 32'h0);
  endtask : bus

  task automatic wr(input logic [11:0] ofs, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, ofs, d, x);
  endtask : wr

  // Poll a start bit until the device drops it
  task automatic poll(input logic [11:0] ofs, input int b);
    logic [31:0] v;
    int n;
    n = 0;
    do begin
      bus(1'b0, ofs, 32'h0, v);
      n++;
    end while (v[b] !== 1'b0 && n < 20);
    chk("start bit clear", {31'h0, v[b]}, 32'h0);
    if (v[b] !== 1'b0) begin
      tally_and_finish();
    end
  endtask : poll

  // Shared control word for the static and multicast tables
  function automatic logic [31:0] ctl(input logic [5:0] s, input logic t, input logic d);
    logic [31:0] v;
    v = 32'h0;
    v[SLT_CTL_SEL_LSB +: 6] = s;
    v[SLT_CTL_GO_BIT] = 1'b1;
    v[SLT_CTL_TBL_BIT] = t;
    v[SLT_CTL_DIR_BIT] = d;
    return v;
  endfunction : ctl

  // VLAN entry words as laid out in the data registers
  function automatic logic [31:0] ve0(input slt_vlan_s e);
    return {18'h0, e.egress_strip_mask, e.membership_mask};
  endfunction : ve0

  function automatic logic [31:0] ve1(input slt_vlan_s e);
    return {16'h0, e.priority_val, e.spanning_instance_number, e.filter_group_id, 2'b00,
            e.membership_route_choice};
  endfunction : ve1

  // Ingress lookup: request on one edge, answer for one cycle after it
  task automatic look(input logic [11:0] id, input logic exp_v, input slt_vlan_s e);
    lkup_vid_in <= id;
    lkup_req_in <= 1'b1;
    tick();
    lkup_req_in <= 1'b0;
    chk("lookup valid", {31'h0, lkup_vld_out}, {31'h0, exp_v});
    if (exp_v) begin
      chk("lookup entry", 32'(lkup_res_out.entry), 32'(e));
      chk("lookup hit", {31'h0, lkup_res_out.hit}, {31'h0, e.valid});
    end
    tick();
  endtask : look

  initial begin
    logic [31:0] v;
    logic [31:0] st2 [4];
    logic [31:0] st3 [4];
    logic [31:0] st4 [4];
    logic [3:0] sel [4];
    logic [6:0] mc [8];
    logic [5:0] a;
    slt_vlan_s ve [4];
    logic [11:0] vid [4];
    void'($urandom(29));
    repeat (10) @(posedge clk_in);
    rstn_in <= 1'b1;
    repeat (5) tick();
    // Reset value and unmapped space
    bus(1'b0, SLT_OFS_STAT_W4, 32'h0, v);
    chk("word4 reset", v, SLT_RST_WORD);
    wr(12'h500, 32'hffffffff);
    bus(1'b0, 12'h500, 32'h0, v);
    chk("unmapped read", v, 32'h0);
    $display("test reset and map done");
    // Static table: write four entries, corner selectors among them
    sel = '{4'h0, 4'hf, 4'h5, 4'ha};
    for (int i = 0; i < 4; i++) begin
      st2[i] = (i == 0) ? 32'hffffffff : $urandom();
      st3[i] = (i == 0) ? 32'hffffffff : $urandom();
      st4[i] = (i == 0) ? 32'hffffffff : $urandom();
      wr(SLT_OFS_STAT_W2, st2[i]);
      wr(SLT_OFS_STAT_W3, st3[i]);
      wr(SLT_OFS_STAT_W4, st4[i]);
      wr(SLT_OFS_STAT_CTL, ctl({2'b00, sel[i]}, 1'b0, 1'b0));
      poll(SLT_OFS_STAT_CTL, SLT_CTL_GO_BIT);
      st2[i] = st2[i] & SLT_W2_MASK;
      st3[i] = st3[i] & SLT_W3_MASK;
    end
    // Static table: datapath view, then read back with a write while busy
    for (int i = 0; i < 4; i++) begin
      stat_sel_in <= sel[i];
      tick();
      chk("static word2 out", stat_w2_out, st2[i]);
      chk("static word3 out", stat_w3_out, st3[i]);
      chk("static word4 out", stat_w4_out, st4[i]);
      wr(SLT_OFS_STAT_CTL, ctl({2'b00, sel[i]}, 1'b0, 1'b1));
      wr(SLT_OFS_STAT_W4, 32'h5a5a5a5a);
      poll(SLT_OFS_STAT_CTL, SLT_CTL_GO_BIT);
      bus(1'b0, SLT_OFS_STAT_W2, 32'h0, v);
      chk("static word2 read", v, st2[i]);
      bus(1'b0, SLT_OFS_STAT_W3, 32'h0, v);
      chk("static word3 read", v, st3[i]);
      bus(1'b0, SLT_OFS_STAT_W4, 32'h0, v);
      chk("static word4 read", v, st4[i]);
    end
    $display("test static table done");
    // Reserved multicast: one write per group of six, edge addresses included
    mc = '{default: 7'h0};
    for (int g = 0; g < 8; g++) begin
      a = (g == 0) ? 6'd0 : (g == 7) ? 6'd47 : 6'(g * 6 + $urandom_range(5));
      v = $urandom();
      mc[a / 6] = v[6:0];
      wr(SLT_OFS_STAT_W2, v);
      wr(SLT_OFS_STAT_CTL, ctl(a, 1'b1, 1'b0));
      poll(SLT_OFS_STAT_CTL, SLT_CTL_GO_BIT);
    end
    for (int i = 0; i < 48; i++) begin
      mc_addr_in <= 6'(i);
      tick();
      chk("mcast mask out", {25'h0, mc_mask_out}, {25'h0, mc[i / 6]});
    end
    for (int g = 0; g < 8; g++) begin
      a = 6'(g * 6 + $urandom_range(5));
      wr(SLT_OFS_STAT_CTL, ctl(a, 1'b1, 1'b1));
      poll(SLT_OFS_STAT_CTL, SLT_CTL_GO_BIT);
      bus(1'b0, SLT_OFS_STAT_W2, 32'h0, v);
      chk("mcast mask read", v, {25'h0, mc[g]});
    end
    $display("test reserved multicast done");
    // VLAN table: program entries at boundary and random VIDs
    vid = '{12'h000, 12'hfff, 12'h401 + 12'($urandom_range(1023)),
            12'h801 + 12'($urandom_range(1023))};
    for (int i = 0; i < 4; i++) begin
      ve[i] = (i == 0) ? slt_vlan_s'('1) : slt_vlan_s'($urandom());
      wr(SLT_OFS_VLAN_E0, ve0(ve[i]));
      wr(SLT_OFS_VLAN_E1, ve1(ve[i]));
      wr(SLT_OFS_VLAN_E2, {31'h0, ve[i].valid});
      wr(SLT_OFS_VLAN_IDX, {20'h0, vid[i]});
      wr(SLT_OFS_VLAN_CTL, 32'h80);
      poll(SLT_OFS_VLAN_CTL, SLT_VCTL_START_BIT);
    end
    // Mode still off: no lookup answer
    look(vid[0], 1'b0, ve[0]);
    for (int i = 0; i < 4; i++) begin
      wr(SLT_OFS_VLAN_E0, 32'h0);
      wr(SLT_OFS_VLAN_E1, 32'h0);
      wr(SLT_OFS_VLAN_E2, 32'h0);
      wr(SLT_OFS_VLAN_IDX, {20'h0, vid[i]});
      wr(SLT_OFS_VLAN_CTL, 32'h81);
      poll(SLT_OFS_VLAN_CTL, SLT_VCTL_START_BIT);
      bus(1'b0, SLT_OFS_VLAN_E0, 32'h0, v);
      chk("vlan word0 read", v, ve0(ve[i]));
      bus(1'b0, SLT_OFS_VLAN_E1, 32'h0, v);
      chk("vlan word1 read", v, ve1(ve[i]));
      bus(1'b0, SLT_OFS_VLAN_E2, 32'h0, v);
      chk("vlan word2 read", v, {31'h0, ve[i].valid});
    end
    // Mode on: ingress lookups select entries by VID
    wr(SLT_OFS_LKUP_CTL, 32'h1);
    for (int i = 0; i < 4; i++) begin
      look(vid[i], 1'b1, ve[i]);
    end
    $display("test vlan table done");
    tally_and_finish();
  end
endmodule : switch_lookup_table_indirect_access_test
